/* hw/dbc_cfg.svh */
/*
  Offsets, field positions, reset values and counts of the converter
  control register bank. Assumes inclusion by bare name from design files.
*/
`ifndef DBC_CFG_SVH
`define DBC_CFG_SVH

`define DBC_ADDR_W 8
`define DBC_DATA_W 8
`define DBC_OFS_FIRST_LIMIT_RAMP 8'h03
`define DBC_OFS_SECOND_CONTROL 8'h04
`define DBC_OFS_SECOND_LIMIT_RAMP 8'h05
`define DBC_RST_SECOND_CONTROL 8'h08
`define DBC_RST_SECOND_LIMIT_RAMP 8'h1A
`define DBC_RST_FIRST_RAMP 3'h2
`define DBC_RST_ILIM 3'h3
`define DBC_RST_SECOND_RAMP 3'h2
`define DBC_CTRL_MASK 8'hFF
`define DBC_LR_MASK 8'hFF
`define DBC_BIT_ON 0
`define DBC_BIT_GATE_LO 1
`define DBC_BIT_GATE_HI 2
`define DBC_BIT_DISCHARGE 3
`define DBC_BIT_FORCED_PWM 4
`define DBC_BIT_RAMP_LO 0
`define DBC_BIT_RAMP_HI 2
`define DBC_BIT_ILIM_LO 3
`define DBC_BIT_ILIM_HI 5
`define DBC_GATE_BIT_ONLY 2'h0
`define DBC_BOOT_SETTLE 2'h2

`endif

/* hw/dbc_pkg.sv */
/*
  Types shared by the converter control bank and its start-up loader.
  Assumes the configuration header is compiled alongside.
*/
package dbc_pkg;

  typedef enum logic [1:0] {
    DBC_BT_WAIT = 2'b00,
    DBC_BT_LOAD = 2'b01,
    DBC_BT_DONE = 2'b10
  } dbc_boot_e;

  typedef logic [2:0] dbc_code3_t;
  typedef logic [1:0] dbc_gate_t;

endpackage

/* hw/dbc_boot_if.sv */
/*
  Interface carrying start-up defaults from the loader to the bank.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/100ps
`default_nettype none

interface dbc_boot_if;
  import dbc_pkg::*;
  logic load;
  logic done;
  logic mode;
  dbc_gate_t gating;
  logic enable;
  dbc_code3_t first_ramp;
  dbc_code3_t second_ramp;

  modport src (
    output load, done, mode, gating, enable, first_ramp, second_ramp
  );
  modport snk (
    input load, done, mode, gating, enable, first_ramp, second_ramp
  );
endinterface

`default_nettype wire

/* hw/dbc_boot_loader.sv */
/*
  Start-up loader: synchronises the one-time-programmed default levels
  and hands them to the bank once, a few cycles after reset release.
  Assumes the default levels are static after power-up.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dbc_cfg.svh"

module dbc_boot_loader
  import dbc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [9:0] otp_bits_i,
  dbc_boot_if.src boot
);

  logic [9:0] otp_meta_ff;
  logic [9:0] otp_sync_ff;
  dbc_boot_e state_ff;
  dbc_boot_e nxt_state;
  logic [1:0] cnt_ff;
  logic [1:0] nxt_cnt;

  // Two flops before any logic reads the levels.
  always_ff @(posedge ref_clk_i) begin
    otp_meta_ff <= otp_bits_i;
    otp_sync_ff <= otp_meta_ff;
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      DBC_BT_WAIT: begin
        nxt_cnt = cnt_ff + 2'h1;
        if (cnt_ff == `DBC_BOOT_SETTLE) begin
          nxt_state = DBC_BT_LOAD;
        end
      end
      DBC_BT_LOAD: begin
        nxt_state = DBC_BT_DONE;
      end
      default: begin
        nxt_state = DBC_BT_DONE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_ff <= DBC_BT_WAIT;
      cnt_ff <= 2'h0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  assign boot.load = (state_ff == DBC_BT_LOAD);
  assign boot.done = (state_ff == DBC_BT_DONE);
  assign boot.mode = otp_sync_ff[9];
  assign boot.gating = otp_sync_ff[8:7];
  assign boot.enable = otp_sync_ff[6];
  assign boot.first_ramp = otp_sync_ff[5:3];
  assign boot.second_ramp = otp_sync_ff[2:0];

endmodule

`default_nettype wire

/* hw/dbc_regs.sv */
/*
  Control register bank of the second step-down converter, plus the ramp
  field of the first converter. Plain register port, enable-pin gating.
  Assumes enable pins and default levels are asynchronous to ref_clk_i.
*/
// Our own choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "dbc_cfg.svh"

module dbc_regs
  import dbc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [2:0] en_pin_i,
  input wire logic [9:0] otp_bits_i,
  output logic [7:0] rd_data_o,
  output logic boot_done_o,
  output logic second_converter_on_o,
  output logic second_forced_pulse_width_o,
  output logic second_discharge_resistor_on_o,
  output logic [2:0] second_peak_current_limit_o,
  output logic [2:0] second_ramp_rate_sel_o,
  output logic [2:0] first_ramp_rate_sel_o
);

  dbc_boot_if boot ();

  dbc_boot_loader u_boot (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .otp_bits_i(otp_bits_i),
    .boot(boot)
  );

  logic [2:0] pin_meta_ff;
  logic [2:0] pin_sync_ff;

  // Synchronise each enable pin.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_pin
      always_ff @(posedge ref_clk_i) begin
        pin_meta_ff[gi] <= en_pin_i[gi];
        pin_sync_ff[gi] <= pin_meta_ff[gi];
      end
    end
  endgenerate

  logic [7:0] ctrl_ff;
  logic [7:0] nxt_ctrl;
  logic [7:0] lr_ff;
  logic [7:0] nxt_lr;
  dbc_code3_t ramp0_ff;
  dbc_code3_t nxt_ramp0;
  logic [7:0] rd_data_ff;
  logic [7:0] nxt_rd_data;
  logic on_ff;
  logic nxt_on;
  logic fpwm_ff;
  logic dis_ff;
  logic nxt_dis;
  logic done_ff;
  logic [2:0] ilim_ff;
  dbc_code3_t ramp1_ff;
  dbc_code3_t ramp0_out_ff;
  logic gate_pin;
  dbc_gate_t gate_sel;

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_lr = lr_ff;
    nxt_ramp0 = ramp0_ff;
    // Stored registers, reserved codes kept as written.
    // no code check
    if (wr_i) begin
      if (addr_i == `DBC_OFS_FIRST_LIMIT_RAMP) begin
        nxt_ramp0 = wr_data_i[`DBC_BIT_RAMP_HI:`DBC_BIT_RAMP_LO];
      end else if (addr_i == `DBC_OFS_SECOND_CONTROL) begin
        nxt_ctrl = wr_data_i & `DBC_CTRL_MASK;
      end else if (addr_i == `DBC_OFS_SECOND_LIMIT_RAMP) begin
        nxt_lr = wr_data_i & `DBC_LR_MASK;
      end
    end
    // Start-up defaults override fields once.
    // default field load
    if (boot.load) begin
      nxt_ctrl[`DBC_BIT_FORCED_PWM] = boot.mode;
      nxt_ctrl[`DBC_BIT_GATE_HI:`DBC_BIT_GATE_LO] = boot.gating;
      nxt_ctrl[`DBC_BIT_ON] = boot.enable;
      nxt_ramp0 = boot.first_ramp;
      nxt_lr[`DBC_BIT_RAMP_HI:`DBC_BIT_RAMP_LO] = boot.second_ramp;
    end
  end

  always_comb begin
    nxt_rd_data = 8'h00;
    if (rd_i) begin
      if (addr_i == `DBC_OFS_FIRST_LIMIT_RAMP) begin
        nxt_rd_data = {5'h00, ramp0_ff};
      end else if (addr_i == `DBC_OFS_SECOND_CONTROL) begin
        nxt_rd_data = ctrl_ff;
      end else if (addr_i == `DBC_OFS_SECOND_LIMIT_RAMP) begin
        nxt_rd_data = lr_ff;
      end
    end
  end

  always_comb begin
    gate_sel = ctrl_ff[`DBC_BIT_GATE_HI:`DBC_BIT_GATE_LO];
    if (gate_sel == `DBC_GATE_BIT_ONLY) begin
      gate_pin = 1'b1;
    end else begin
      gate_pin = pin_sync_ff[gate_sel - 2'h1];
    end
    nxt_on = ctrl_ff[`DBC_BIT_ON] & gate_pin;
    nxt_dis = ctrl_ff[`DBC_BIT_DISCHARGE] & ~nxt_on;
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ctrl_ff <= `DBC_RST_SECOND_CONTROL;
      lr_ff <= `DBC_RST_SECOND_LIMIT_RAMP;
      ramp0_ff <= `DBC_RST_FIRST_RAMP;
      rd_data_ff <= 8'h00;
      on_ff <= 1'b0;
      fpwm_ff <= 1'b0;
      dis_ff <= 1'b1;
      done_ff <= 1'b0;
      ilim_ff <= `DBC_RST_ILIM;
      ramp1_ff <= `DBC_RST_SECOND_RAMP;
      ramp0_out_ff <= `DBC_RST_FIRST_RAMP;
    end else begin
      ctrl_ff <= nxt_ctrl;
      lr_ff <= nxt_lr;
      ramp0_ff <= nxt_ramp0;
      rd_data_ff <= nxt_rd_data;
      on_ff <= nxt_on;
      fpwm_ff <= ctrl_ff[`DBC_BIT_FORCED_PWM];
      dis_ff <= nxt_dis;
      done_ff <= boot.done;
      ilim_ff <= lr_ff[`DBC_BIT_ILIM_HI:`DBC_BIT_ILIM_LO];
      ramp1_ff <= lr_ff[`DBC_BIT_RAMP_HI:`DBC_BIT_RAMP_LO];
      ramp0_out_ff <= ramp0_ff;
    end
  end

  assign rd_data_o = rd_data_ff;
  assign boot_done_o = done_ff;
  assign second_converter_on_o = on_ff;
  assign second_forced_pulse_width_o = fpwm_ff;
  assign second_discharge_resistor_on_o = dis_ff;
  assign second_peak_current_limit_o = ilim_ff;
  assign second_ramp_rate_sel_o = ramp1_ff;
  assign first_ramp_rate_sel_o = ramp0_out_ff;

  // Checks on the bank.
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  property p_ramp0_write;
    wr_i && addr_i == `DBC_OFS_FIRST_LIMIT_RAMP && !boot.load |=>
      ##1 first_ramp_rate_sel_o == $past(wr_data_i[2:0], 2);
  endproperty
  a_ramp0_write: assert property (p_ramp0_write)
    else $error("first ramp output does not follow write");

  property p_mode;
    ##1 second_forced_pulse_width_o == $past(ctrl_ff[4]);
  endproperty
  a_mode: assert property (p_mode)
    else $error("forced pulse width output wrong");

  property p_discharge;
    second_discharge_resistor_on_o |-> !second_converter_on_o;
  endproperty
  a_discharge: assert property (p_discharge)
    else $error("discharge on while converter on");

  property p_gate_pin;
    (ctrl_ff[2:0] == 3'b101 && !en_pin_i[1])[*4] |=>
      !second_converter_on_o;
  endproperty
  a_gate_pin: assert property (p_gate_pin)
    else $error("pin two gating ignored");

  property p_enable_off;
    !ctrl_ff[0] |=> !second_converter_on_o;
  endproperty
  a_enable_off: assert property (p_enable_off)
    else $error("converter on with enable bit clear");

  property p_rd_ctrl;
    rd_i && addr_i == 8'h04 |=> rd_data_o == $past(ctrl_ff) ##1
      rd_data_o == 8'h00 || $past(rd_i);
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl)
    else $error("control read data wrong");

  property p_rd_lr;
    wr_i && addr_i == 8'h05 && !boot.load ##1 rd_i && addr_i == 8'h05
      |=> rd_data_o == $past(wr_data_i, 2);
  endproperty
  a_rd_lr: assert property (p_rd_lr)
    else $error("limit ramp read back wrong");

  property p_boot_load;
    boot.load |=> ctrl_ff[0] == $past(boot.enable) &&
      ctrl_ff[2:1] == $past(boot.gating) && lr_ff[2:0] ==
      $past(boot.second_ramp);
  endproperty
  a_boot_load: assert property (p_boot_load)
    else $error("default load not applied");

  property p_ilim;
    wr_i && addr_i == 8'h05 && !boot.load |=>
      ##1 second_peak_current_limit_o == $past(wr_data_i[5:3], 2);
  endproperty
  a_ilim: assert property (p_ilim)
    else $error("current limit output wrong");

  property p_on_sync;
    (ctrl_ff[2:0] == 3'b111 && en_pin_i[2])[*4] |=> second_converter_on_o;
  endproperty
  a_on_sync: assert property (p_on_sync)
    else $error("gated enable not raised");

  c_on_rise: cover property ($rose(second_converter_on_o));
  c_boot: cover property ($rose(boot_done_o));
  c_reserved_ilim: cover property (wr_i && addr_i == 8'h05 &&
    wr_data_i[5:3] == 3'h7);

endmodule

`default_nettype wire

/* dv/dbc_regs_tb.sv */
/*
  Self-checking bench for the converter control bank.
  Assumes the bank and its header are compiled ahead of it.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dbc_cfg.svh"

module tb;
  import dbc_pkg::*;
  typedef struct packed {
    logic [7:0] d;
    logic [2:0] pin;
    logic [2:0] exp;
  } dbc_row_s;
  localparam logic [9:0] OTP = 10'h2EE;
  logic ref_clk_i, reset_i, wr_i, rd_i;
  logic [7:0] addr_i, wr_data_i, rd_data_o;
  logic [2:0] en_pin_i, ilim, ramp2, ramp1;
  logic [9:0] otp_bits_i;
  logic done, on, fpwm, dis;
  logic [2:0] c;
  int err_count, tests_run, i;
  dbc_row_s rows [10] = '{'{8'h01, 3'h0, 3'b100}, '{8'h09, 3'h0, 3'b100},
    '{8'h0B, 3'h0, 3'b001}, '{8'h0B, 3'h1, 3'b100},
    '{8'h0D, 3'h1, 3'b001}, '{8'h0D, 3'h2, 3'b100},
    '{8'h0F, 3'h3, 3'b001}, '{8'h1F, 3'h4, 3'b110},
    '{8'h18, 3'h7, 3'b011}, '{8'hE0, 3'h7, 3'b000}};

  dbc_regs dbc_regs_i (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .addr_i(addr_i),
    .wr_data_i(wr_data_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .en_pin_i(en_pin_i),
    .otp_bits_i(otp_bits_i),
    .rd_data_o(rd_data_o),
    .boot_done_o(done),
    .second_converter_on_o(on),
    .second_forced_pulse_width_o(fpwm),
    .second_discharge_resistor_on_o(dis),
    .second_peak_current_limit_o(ilim),
    .second_ramp_rate_sel_o(ramp2),
    .first_ramp_rate_sel_o(ramp1)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string m);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 chk(rd_data_o, e, "read data");
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  task automatic boot;
    int k;
    @(posedge ref_clk_i);
    reset_i <= 1'b1;
    idle(16);
    reset_i <= 1'b0;
    #1 chk({1'b0, on, fpwm, dis, 1'b0, ilim}, 8'h13, "reset outputs");
    chk({2'h0, ramp2, ramp1}, 8'h12, "reset ramps");
    chk(rd_data_o, 8'h00, "reset read data");
    for (k = 0; k < 50 && done !== 1'b1; k++) begin
      @(posedge ref_clk_i);
    end
    if (done !== 1'b1) begin
      err_count++;
      $display("[FAIL] %0t start-up load never finished", $time);
      end_sim();
    end
  endtask

  initial begin
    reset_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wr_data_i = 8'h00;
    en_pin_i = 3'h0;
    otp_bits_i = OTP;
    boot();
    rd(`DBC_OFS_SECOND_CONTROL, 8'h1B);
    rd(`DBC_OFS_SECOND_LIMIT_RAMP, 8'h1E);
    rd(`DBC_OFS_FIRST_LIMIT_RAMP, 8'h05);
    chk({5'h0, on, fpwm, dis}, 8'h03, "default outputs");
    $display("test defaults done");
    for (i = 0; i < 10; i++) begin
      @(posedge ref_clk_i);
      en_pin_i <= rows[i].pin;
      wr(`DBC_OFS_SECOND_CONTROL, rows[i].d);
      idle(5);
      rd(`DBC_OFS_SECOND_CONTROL, rows[i].d);
      chk({5'h0, on, fpwm, dis}, {5'h0, rows[i].exp}, "control row");
    end
    $display("test control rows done");
    for (i = 0; i < 8; i++) begin
      c = i[2:0];
      wr(`DBC_OFS_SECOND_LIMIT_RAMP, {2'h2, c, ~c});
      idle(2);
      rd(`DBC_OFS_SECOND_LIMIT_RAMP, {2'h2, c, ~c});
      chk({2'h0, ilim, ramp2}, {2'h0, c, ~c}, "limit and ramp");
      wr(`DBC_OFS_FIRST_LIMIT_RAMP, {5'h1F, c});
      idle(2);
      rd(`DBC_OFS_FIRST_LIMIT_RAMP, {5'h00, c});
      chk({5'h0, ramp1}, {5'h0, c}, "first ramp");
    end
    $display("test codes done");
    wr(`DBC_OFS_SECOND_LIMIT_RAMP, 8'h2B);
    @(posedge ref_clk_i);
    #1 chk({2'h0, ilim, ramp2}, 8'h2B, "limit update timing");
    wr(8'h06, 8'hFF);
    rd(8'h06, 8'h00);
    rd(8'h02, 8'h00);
    rd(`DBC_OFS_SECOND_CONTROL, 8'hE0);
    $display("test unmapped done");
    @(posedge ref_clk_i);
    addr_i <= `DBC_OFS_SECOND_CONTROL;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    addr_i <= `DBC_OFS_SECOND_LIMIT_RAMP;
    #1 chk(rd_data_o, 8'hE0, "first of two reads");
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 chk(rd_data_o, 8'h2B, "second of two reads");
    @(posedge ref_clk_i);
    #1 chk(rd_data_o, 8'h00, "read data released");
    @(posedge ref_clk_i);
    addr_i <= `DBC_OFS_SECOND_LIMIT_RAMP;
    wr_data_i <= 8'h35;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 chk(rd_data_o, 8'h35, "write then read");
    chk({2'h0, ilim, ramp2}, 8'h35, "write then read outputs");
    $display("test back to back done");
    boot();
    rd(`DBC_OFS_SECOND_CONTROL, 8'h1B);
    rd(`DBC_OFS_SECOND_LIMIT_RAMP, 8'h1E);
    $display("test second reset done");
    end_sim();
  end
endmodule

`default_nettype wire
